// ### rtl/iorw_pkg.sv
// register window offsets, host types and carrier structs for the i/o register window
package iorw_pkg;
	localparam logic [7:0] OFS_A_PIN    = 8'h00;
	localparam logic [7:0] OFS_B_PIN    = 8'h01;
	localparam logic [7:0] OFS_A_MODE   = 8'h02;
	localparam logic [7:0] OFS_B_MODE   = 8'h03;
	localparam logic [7:0] OFS_A_OUT    = 8'h04;
	localparam logic [7:0] OFS_B_OUT    = 8'h05;
	localparam logic [7:0] OFS_A_DIR    = 8'h06;
	localparam logic [7:0] OFS_B_DIR    = 8'h07;
	localparam logic [7:0] OFS_A_DRV    = 8'h08;
	localparam logic [7:0] OFS_B_DRV    = 8'h09;
	localparam logic [7:0] OFS_A_ICELL  = 8'h0A;
	localparam logic [7:0] OFS_B_ICELL  = 8'h0B;
	localparam logic [7:0] OFS_A_OE     = 8'h0C;
	localparam logic [7:0] OFS_B_OE     = 8'h0D;
	localparam logic [7:0] OFS_C_PIN    = 8'h10;
	localparam logic [7:0] OFS_D_PIN    = 8'h11;
	localparam logic [7:0] OFS_C_OUT    = 8'h12;
	localparam logic [7:0] OFS_D_OUT    = 8'h13;
	localparam logic [7:0] OFS_C_DIR    = 8'h14;
	localparam logic [7:0] OFS_D_DIR    = 8'h15;
	localparam logic [7:0] OFS_C_DRV    = 8'h16;
	localparam logic [7:0] OFS_D_DRV    = 8'h17;
	localparam logic [7:0] OFS_C_ICELL  = 8'h18;
	localparam logic [7:0] OFS_C_OE     = 8'h1A;
	localparam logic [7:0] OFS_D_OE     = 8'h1B;
	localparam logic [7:0] OFS_CELL_AB  = 8'h20;
	localparam logic [7:0] OFS_CELL_BC  = 8'h21;
	localparam logic [7:0] OFS_MASK_AB  = 8'h22;
	localparam logic [7:0] OFS_MASK_BC  = 8'h23;
	localparam logic [7:0] OFS_PWR0     = 8'hB0;
	localparam logic [7:0] OFS_PWR2     = 8'hB4;
	localparam logic [7:0] OFS_PRI_PROT = 8'hC0;
	localparam logic [7:0] OFS_SEC_PROT = 8'hC2;
	localparam logic [7:0] OFS_DBG_EN   = 8'hC7;
	localparam logic [7:0] OFS_PAGE     = 8'hE0;
	localparam logic [7:0] OFS_MEM_PLC  = 8'hE2;

	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] PORT_D_MASK   = 8'h07;
	// pins 7..4 of ports a/b and all of port c may be open drain; pins 3..0 of ports a/b get slew select
	localparam logic [7:0] AB_OD_CAPABLE = 8'hF0;
	localparam logic [7:0] C_OD_CAPABLE  = 8'hFF;
	localparam int         PD_STROBE_BIT = 0;
	localparam int         PD_LCLK_BIT   = 1;
	localparam int         PD_CSEL_BIT   = 2;
	localparam int         PC_TDI_BIT    = 5;
	localparam int         PC_TDO_BIT    = 6;
	localparam int         PC_DBE_BIT    = 7;
	localparam int         PWR0_APD_EN   = 1;
	localparam logic [7:0] APD_LIMIT     = 8'hFF;

	typedef enum logic [1:0] {
		IORW_HOST_GENERIC_MUX = 2'b00,
		IORW_HOST_WIDE_8BIT   = 2'b01,
		IORW_HOST_PAGE_MODE   = 2'b10,
		IORW_HOST_NON_MUX     = 2'b11
	} iorw_host_t;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
	} iorw_ports_t;

	typedef struct packed {
		logic strobe_on_d0;
		logic logic_clk_on_d1;
		logic chip_sel_on_d2;
		logic byte_en_on_c7;
	} iorw_pin_func_t;

	typedef struct packed {
		logic [7:0]  mode_a;
		logic [7:0]  mode_b;
		iorw_ports_t out_latch;
		iorw_ports_t dir;
		iorw_ports_t drv;
		iorw_ports_t pin_in;
		logic [7:0]  icell_a;
		logic [7:0]  icell_b;
		logic [7:0]  icell_c;
		logic [7:0]  cell_ab;
		logic [7:0]  cell_bc;
		logic [7:0]  mask_ab;
		logic [7:0]  mask_bc;
		logic [7:0]  pwr0;
		logic [7:0]  pwr2;
		logic [7:0]  dbg_en;
		logic [7:0]  page;
		logic [7:0]  mem_plc;
		logic [15:0] lat_addr;
		logic        lclk_prev;
		logic [7:0]  apd_cnt;
		logic        apd_down;
		logic        mem_en;
		iorw_ports_t pin_out;
		iorw_ports_t pin_oe;
		logic [15:0] fast_slew;
		logic        tdi;
		logic [7:0]  rdata;
		logic        rvalid;
	} iorw_state_t;
endpackage

// ### rtl/iorw_io_register_window.sv
// host register window with port pin control, macrocell access and status registers
// Notes on behaviour
// (RULE1) window is 256 bytes at user base
// (RULE2) pin input registers return live pin levels
// (RULE3) port a/b mode picks i/o or address out
// (RULE4) output latches drive pins in output mode
// (RULE5) direction registers set pin input or output
// (RULE6) drive registers pick open drain or slew; the port d drive register is only stored and read back, its pins get neither
// (RULE7) enable-out registers read pin driver enables
// (RULE8) offset 20 reads/loads cell group ab
// (RULE9) offset 21 reads/loads cell group bc
// (RULE10) mask 22 blocks host writes to ab bits
// (RULE11) mask 23 blocks host writes to bc bits
// (RULE12) c0 reads primary sector protection, read-only
// (RULE13) c2 reads security and secondary protection, read-only
// (RULE14) power control registers at b0 and b4
// (RULE15) e2 places memory areas in program/data space
// (RULE16) host type selects latched address nibble mapping
// (RULE17) port d bit0 strobe captures multiplexed address
// (RULE18) port d bit1 clocks cells and power-down counter
// (RULE19) port d bit2 high disables memory, blocks access
// (RULE20) port c bit7 is active-low byte enable
// (RULE21) port c bits 5/6 carry debug data in/out
// (RULE22) unmapped offsets ignore writes, read zero
`timescale 1ns/1ps
module iorw_io_register_window
	import iorw_pkg::*;
(
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	input  wire logic [7:0]     window_base_in,
	input  wire iorw_host_t     host_type_in,
	input  wire iorw_pin_func_t pin_func_in,
	input  wire logic [15:0]    host_addr_in,
	input  wire logic [7:0]     host_data_in,
	input  wire logic           host_rd_in,
	input  wire logic           host_wr_in,
	input  wire iorw_ports_t    port_pin_in,
	input  wire logic [7:0]     cell_ab_d_in,
	input  wire logic [7:0]     cell_bc_d_in,
	input  wire logic [7:0]     primary_protect_in,
	input  wire logic [7:0]     secondary_security_in,
	input  wire logic           debug_tdo_in,
	output logic [7:0]          host_rdata_out,
	output logic                host_rvalid_out,
	output iorw_ports_t         port_pin_out,
	output iorw_ports_t         port_pin_oe_out,
	output logic [15:0]         fast_slew_out,
	output logic [7:0]          cell_ab_out,
	output logic [7:0]          cell_bc_out,
	output logic [7:0]          power_control_0_out,
	output logic [7:0]          power_control_2_out,
	output logic [7:0]          page_select_out,
	output logic [7:0]          memory_space_placement_out,
	output logic [7:0]          debug_port_enable_out,
	output logic                debug_tdi_out,
	output logic                memory_enable_out,
	output logic                auto_powerdown_out
);

	iorw_state_t st_r;
	iorw_state_t st_nxt;

	// {valid, nibble index of the latched address} for port/half; invalid halves stay plain i/o
	function automatic logic [2:0] addr_nibble(input iorw_host_t ht, input logic port_b, input logic hi);
		logic [2:0] r;
		r = 3'b000;
		case (ht)
			IORW_HOST_GENERIC_MUX: r = {1'b1, 1'b0, hi}; // [RULE16]
			IORW_HOST_WIDE_8BIT: begin
				if (!port_b && hi)
					r = 3'b101;
				else if (port_b && !hi)
					r = 3'b110;
			end
			IORW_HOST_PAGE_MODE: begin
				if (port_b)
					r = {1'b1, 1'b1, hi};
			end
			IORW_HOST_NON_MUX: begin
				if (port_b)
					r = {1'b1, 1'b0, hi};
			end
			default: r = 3'b000;
		endcase
		return r;
	endfunction

	// one pin driver: address out overrides the latch; open drain only ever pulls low
	function automatic logic [1:0] pin_drive(input logic addr_sel, input logic addr_bit,
			input logic latch, input logic dir, input logic od);
		logic [1:0] r;
		if (addr_sel)
			r = {addr_bit, 1'b1}; // [RULE3]
		else if (od)
			r = {1'b0, dir & ~latch}; // [RULE6]
		else
			r = {latch, dir}; // [RULE4] [RULE5]
		return r;
	endfunction

	logic [15:0] eff_addr;
	logic        in_window;
	logic        csel_ok;
	logic        dbe_ok;
	logic        rd_hit;
	logic        wr_hit;
	logic [7:0]  ofs;
	logic        lclk_tick;
	logic [7:0]  rd_val;
	logic [2:0]  nib;
	logic [1:0]  drv;
	logic [3:0]  addr_nib;

	always_comb begin
		st_nxt = st_r;
		rd_val = 8'h00;
		nib = 3'b000;
		drv = 2'b00;
		addr_nib = 4'h0;

		st_nxt.pin_in = port_pin_in;
		st_nxt.pin_in.d = port_pin_in.d & PORT_D_MASK;

		// multiplexed hosts put the low address byte on the data lines while the strobe is high
		if (pin_func_in.strobe_on_d0 && host_type_in != IORW_HOST_NON_MUX) begin
			if (port_pin_in.d[PD_STROBE_BIT])
				st_nxt.lat_addr = {host_addr_in[15:8], host_data_in}; // [RULE17]
		end else begin
			st_nxt.lat_addr = host_addr_in;
		end
		eff_addr = (pin_func_in.strobe_on_d0 && host_type_in != IORW_HOST_NON_MUX) ?
			{host_addr_in[15:8], st_r.lat_addr[7:0]} : host_addr_in;

		csel_ok = !pin_func_in.chip_sel_on_d2 || !port_pin_in.d[PD_CSEL_BIT]; // [RULE19]
		dbe_ok = !pin_func_in.byte_en_on_c7 || !port_pin_in.c[PC_DBE_BIT]; // [RULE20]
		in_window = (eff_addr[15:8] == window_base_in); // [RULE1]
		ofs = eff_addr[7:0];
		rd_hit = host_rd_in && in_window && csel_ok && dbe_ok;
		wr_hit = host_wr_in && in_window && csel_ok && dbe_ok;
		st_nxt.mem_en = csel_ok;

		// without the external logic clock the cells run on every system clock
		// live pin against last cycle's level; prev resets high so a pin that
		// idles high gives no false tick straight after reset
		lclk_tick = pin_func_in.logic_clk_on_d1 ?
			(port_pin_in.d[PD_LCLK_BIT] && !st_r.lclk_prev) : 1'b1; // [RULE18]
		st_nxt.lclk_prev = port_pin_in.d[PD_LCLK_BIT];

		if (lclk_tick) begin
			st_nxt.cell_ab = cell_ab_d_in; // [RULE18]
			st_nxt.cell_bc = cell_bc_d_in;
			st_nxt.icell_a = st_r.pin_in.a;
			st_nxt.icell_b = st_r.pin_in.b;
			st_nxt.icell_c = st_r.pin_in.c;
		end

		// power-down counter advances on logic clock while the host is idle
		// any host access restarts the count, so a busy host never powers down
		if (!st_r.pwr0[PWR0_APD_EN] || host_rd_in || host_wr_in) begin
			st_nxt.apd_cnt = 8'h00;
			st_nxt.apd_down = 1'b0;
		end else if (lclk_tick) begin
			if (st_r.apd_cnt == APD_LIMIT)
				st_nxt.apd_down = 1'b1; // [RULE18]
			else
				st_nxt.apd_cnt = st_r.apd_cnt + 8'h01;
		end

		// host writes win over the logic clock in the same cycle
		if (wr_hit) begin
			if (ofs == OFS_A_MODE)
				st_nxt.mode_a = host_data_in; // [RULE3]
			else if (ofs == OFS_B_MODE)
				st_nxt.mode_b = host_data_in;
			else if (ofs == OFS_A_OUT)
				st_nxt.out_latch.a = host_data_in; // [RULE4]
			else if (ofs == OFS_B_OUT)
				st_nxt.out_latch.b = host_data_in;
			else if (ofs == OFS_C_OUT)
				st_nxt.out_latch.c = host_data_in;
			else if (ofs == OFS_D_OUT)
				st_nxt.out_latch.d = host_data_in & PORT_D_MASK;
			else if (ofs == OFS_A_DIR)
				st_nxt.dir.a = host_data_in; // [RULE5]
			else if (ofs == OFS_B_DIR)
				st_nxt.dir.b = host_data_in;
			else if (ofs == OFS_C_DIR)
				st_nxt.dir.c = host_data_in;
			else if (ofs == OFS_D_DIR)
				st_nxt.dir.d = host_data_in & PORT_D_MASK;
			else if (ofs == OFS_A_DRV)
				st_nxt.drv.a = host_data_in; // [RULE6]
			else if (ofs == OFS_B_DRV)
				st_nxt.drv.b = host_data_in;
			else if (ofs == OFS_C_DRV)
				st_nxt.drv.c = host_data_in;
			else if (ofs == OFS_D_DRV)
				st_nxt.drv.d = host_data_in & PORT_D_MASK;
			else if (ofs == OFS_CELL_AB)
				st_nxt.cell_ab = (host_data_in & ~st_r.mask_ab) | (st_nxt.cell_ab & st_r.mask_ab); // [RULE8] [RULE10]
			else if (ofs == OFS_CELL_BC)
				st_nxt.cell_bc = (host_data_in & ~st_r.mask_bc) | (st_nxt.cell_bc & st_r.mask_bc); // [RULE9] [RULE11]
			else if (ofs == OFS_MASK_AB)
				st_nxt.mask_ab = host_data_in; // [RULE10]
			else if (ofs == OFS_MASK_BC)
				st_nxt.mask_bc = host_data_in; // [RULE11]
			else if (ofs == OFS_PWR0)
				st_nxt.pwr0 = host_data_in; // [RULE14]
			else if (ofs == OFS_PWR2)
				st_nxt.pwr2 = host_data_in; // [RULE14]
			else if (ofs == OFS_DBG_EN)
				st_nxt.dbg_en = host_data_in;
			else if (ofs == OFS_PAGE)
				st_nxt.page = host_data_in;
			else if (ofs == OFS_MEM_PLC)
				st_nxt.mem_plc = host_data_in; // [RULE15]
			// protection registers and unmapped offsets take no write [RULE12] [RULE13] [RULE22]
		end

		if (ofs == OFS_A_PIN)
			rd_val = st_r.pin_in.a; // [RULE2]
		else if (ofs == OFS_B_PIN)
			rd_val = st_r.pin_in.b;
		else if (ofs == OFS_C_PIN)
			rd_val = st_r.pin_in.c;
		else if (ofs == OFS_D_PIN)
			rd_val = st_r.pin_in.d;
		else if (ofs == OFS_A_MODE)
			rd_val = st_r.mode_a;
		else if (ofs == OFS_B_MODE)
			rd_val = st_r.mode_b;
		else if (ofs == OFS_A_OUT)
			rd_val = st_r.out_latch.a;
		else if (ofs == OFS_B_OUT)
			rd_val = st_r.out_latch.b;
		else if (ofs == OFS_C_OUT)
			rd_val = st_r.out_latch.c;
		else if (ofs == OFS_D_OUT)
			rd_val = st_r.out_latch.d;
		else if (ofs == OFS_A_DIR)
			rd_val = st_r.dir.a;
		else if (ofs == OFS_B_DIR)
			rd_val = st_r.dir.b;
		else if (ofs == OFS_C_DIR)
			rd_val = st_r.dir.c;
		else if (ofs == OFS_D_DIR)
			rd_val = st_r.dir.d;
		else if (ofs == OFS_A_DRV)
			rd_val = st_r.drv.a;
		else if (ofs == OFS_B_DRV)
			rd_val = st_r.drv.b;
		else if (ofs == OFS_C_DRV)
			rd_val = st_r.drv.c;
		else if (ofs == OFS_D_DRV)
			rd_val = st_r.drv.d;
		else if (ofs == OFS_A_ICELL)
			rd_val = st_r.icell_a;
		else if (ofs == OFS_B_ICELL)
			rd_val = st_r.icell_b;
		else if (ofs == OFS_C_ICELL)
			rd_val = st_r.icell_c;
		else if (ofs == OFS_A_OE)
			rd_val = st_r.pin_oe.a; // [RULE7]
		else if (ofs == OFS_B_OE)
			rd_val = st_r.pin_oe.b;
		else if (ofs == OFS_C_OE)
			rd_val = st_r.pin_oe.c;
		else if (ofs == OFS_D_OE)
			rd_val = st_r.pin_oe.d;
		else if (ofs == OFS_CELL_AB)
			rd_val = st_r.cell_ab; // [RULE8]
		else if (ofs == OFS_CELL_BC)
			rd_val = st_r.cell_bc; // [RULE9]
		else if (ofs == OFS_MASK_AB)
			rd_val = st_r.mask_ab;
		else if (ofs == OFS_MASK_BC)
			rd_val = st_r.mask_bc;
		else if (ofs == OFS_PWR0)
			rd_val = st_r.pwr0;
		else if (ofs == OFS_PWR2)
			rd_val = st_r.pwr2;
		else if (ofs == OFS_PRI_PROT)
			rd_val = primary_protect_in; // [RULE12]
		else if (ofs == OFS_SEC_PROT)
			rd_val = secondary_security_in; // [RULE13]
		else if (ofs == OFS_DBG_EN)
			rd_val = st_r.dbg_en;
		else if (ofs == OFS_PAGE)
			rd_val = st_r.page;
		else if (ofs == OFS_MEM_PLC)
			rd_val = st_r.mem_plc;
		else
			rd_val = 8'h00; // [RULE22]

		st_nxt.rvalid = rd_hit;
		st_nxt.rdata = rd_hit ? rd_val : 8'h00;

		// pin drivers; address-out uses the latched bus address
		for (int i = 0; i < 8; i++) begin
			nib = addr_nibble(host_type_in, 1'b0, i[2]);
			addr_nib = st_r.lat_addr[4 * nib[1:0] +: 4];
			drv = pin_drive(st_r.mode_a[i] && nib[2], addr_nib[i % 4], st_r.out_latch.a[i],
				st_r.dir.a[i], st_r.drv.a[i] && AB_OD_CAPABLE[i]); // [RULE16]
			st_nxt.pin_out.a[i] = drv[1];
			st_nxt.pin_oe.a[i] = drv[0];
			nib = addr_nibble(host_type_in, 1'b1, i[2]);
			addr_nib = st_r.lat_addr[4 * nib[1:0] +: 4];
			drv = pin_drive(st_r.mode_b[i] && nib[2], addr_nib[i % 4], st_r.out_latch.b[i],
				st_r.dir.b[i], st_r.drv.b[i] && AB_OD_CAPABLE[i]);
			st_nxt.pin_out.b[i] = drv[1];
			st_nxt.pin_oe.b[i] = drv[0];
			drv = pin_drive(1'b0, 1'b0, st_r.out_latch.c[i], st_r.dir.c[i],
				st_r.drv.c[i] && C_OD_CAPABLE[i]);
			st_nxt.pin_out.c[i] = drv[1];
			st_nxt.pin_oe.c[i] = drv[0];
			drv = pin_drive(1'b0, 1'b0, st_r.out_latch.d[i], st_r.dir.d[i], 1'b0);
			st_nxt.pin_out.d[i] = drv[1] & PORT_D_MASK[i];
			st_nxt.pin_oe.d[i] = drv[0] & PORT_D_MASK[i];
		end
		// slew select only on the low nibbles, which have no open-drain option
		st_nxt.fast_slew = {st_r.drv.b & ~AB_OD_CAPABLE, st_r.drv.a & ~AB_OD_CAPABLE}; // [RULE6]

		// debug port borrows c5 as input and c6 as output while enabled
		st_nxt.tdi = st_r.pin_in.c[PC_TDI_BIT]; // [RULE21]
		if (st_r.dbg_en != 8'h00) begin
			st_nxt.pin_out.c[PC_TDI_BIT] = 1'b0;
			st_nxt.pin_oe.c[PC_TDI_BIT] = 1'b0;
			st_nxt.pin_out.c[PC_TDO_BIT] = debug_tdo_in; // [RULE21]
			st_nxt.pin_oe.c[PC_TDO_BIT] = 1'b1;
		end
		// strobe, logic clock, chip select and byte enable pins are inputs only
		if (pin_func_in.strobe_on_d0)
			st_nxt.pin_oe.d[PD_STROBE_BIT] = 1'b0;
		if (pin_func_in.logic_clk_on_d1)
			st_nxt.pin_oe.d[PD_LCLK_BIT] = 1'b0;
		if (pin_func_in.chip_sel_on_d2)
			st_nxt.pin_oe.d[PD_CSEL_BIT] = 1'b0;
		if (pin_func_in.byte_en_on_c7)
			st_nxt.pin_oe.c[PC_DBE_BIT] = 1'b0;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r           <= '0;
			st_r.lclk_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign host_rdata_out             = st_r.rdata;
	assign host_rvalid_out            = st_r.rvalid;
	assign port_pin_out               = st_r.pin_out;
	assign port_pin_oe_out            = st_r.pin_oe;
	assign fast_slew_out              = st_r.fast_slew;
	assign cell_ab_out                = st_r.cell_ab;
	assign cell_bc_out                = st_r.cell_bc;
	assign power_control_0_out        = st_r.pwr0;
	assign power_control_2_out        = st_r.pwr2;
	assign page_select_out            = st_r.page;
	assign memory_space_placement_out = st_r.mem_plc;
	assign debug_port_enable_out      = st_r.dbg_en;
	assign debug_tdi_out              = st_r.tdi;
	assign memory_enable_out          = st_r.mem_en;
	assign auto_powerdown_out         = st_r.apd_down;
endmodule

// ### bench/iorw_monitor.sv
// port-level assertions for the i/o register window
`timescale 1ns/1ps
module iorw_monitor
	import iorw_pkg::*;
(
	input wire logic           sys_clk_in,
	input wire logic           rst_n_in,
	input wire logic [7:0]     window_base_in,
	input wire iorw_host_t     host_type_in,
	input wire iorw_pin_func_t pin_func_in,
	input wire logic [15:0]    host_addr_in,
	input wire logic [7:0]     host_data_in,
	input wire logic           host_rd_in,
	input wire logic           host_wr_in,
	input wire iorw_ports_t    port_pin_in,
	input wire logic [7:0]     primary_protect_in,
	input wire logic [7:0]     host_rdata_out,
	input wire logic           host_rvalid_out,
	input wire logic [7:0]     power_control_0_out,
	input wire logic [7:0]     memory_space_placement_out,
	input wire logic [7:0]     debug_port_enable_out,
	input wire logic           debug_tdi_out,
	input wire logic           memory_enable_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic cs_off = pin_func_in.chip_sel_on_d2 && port_pin_in.d[PD_CSEL_BIT];
	wire logic hit = host_addr_in[15:8] == window_base_in && !cs_off
		&& !(pin_func_in.byte_en_on_c7 && port_pin_in.c[PC_DBE_BIT]);
	// strobed hosts carry the offset on the data bus, so offset checks skip them
	wire logic direct = !pin_func_in.strobe_on_d0 || host_type_in == IORW_HOST_NON_MUX;
	sequence rd_s;
		host_rd_in && hit;
	endsequence
	sequence rd_at(logic [7:0] o);
		rd_s ##0 (direct && host_addr_in[7:0] == o);
	endsequence
	sequence wr_at(logic [7:0] o);
		host_wr_in && hit && direct && host_addr_in[7:0] == o;
	endsequence

	rd_answer_a: assert property (rd_s |=> host_rvalid_out)
		else $error("read in window got no data strobe");
	no_hit_quiet_a: assert property (!(host_rd_in && hit) |=> !host_rvalid_out)
		else $error("data strobe without accepted read");
	rdata_idle_a: assert property (!host_rvalid_out |-> host_rdata_out == 8'h00)
		else $error("read data not zero while idle");
	pri_status_a: assert property (rd_at(OFS_PRI_PROT) |=> host_rdata_out == $past(primary_protect_in))
		else $error("protection status read wrong");
	pwr_copy_a: assert property (wr_at(OFS_PWR0) |=> power_control_0_out == $past(host_data_in))
		else $error("power control 0 not loaded");
	plc_copy_a: assert property (wr_at(OFS_MEM_PLC) |=> memory_space_placement_out == $past(host_data_in))
		else $error("placement register not loaded");
	mem_follow_a: assert property (1'b1 |=> memory_enable_out == !$past(cs_off))
		else $error("memory enable does not follow chip select");
	tdi_follow_a: assert property (debug_port_enable_out != 8'h00 |=> debug_tdi_out == $past(port_pin_in.c[PC_TDI_BIT], 2))
		else $error("debug data in not following pin");
endmodule

bind iorw_io_register_window iorw_monitor i_mon (.sys_clk_in, .rst_n_in, .window_base_in, .host_type_in,
	.pin_func_in, .host_addr_in, .host_data_in, .host_rd_in, .host_wr_in, .port_pin_in, .primary_protect_in,
	.host_rdata_out, .host_rvalid_out, .power_control_0_out, .memory_space_placement_out,
	.debug_port_enable_out, .debug_tdi_out, .memory_enable_out);

// ### bench/iorw_host_model.sv
// host microcontroller bus model: accesses, address strobe, chip select, byte enable
`timescale 1ns/1ps
module iorw_host_model
	import iorw_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic [7:0] base_in,
	input  wire logic       refuse_cs_in,
	input  wire logic       refuse_be_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output logic [15:0]     addr_out = 16'hFFFF,
	output logic [7:0]      data_out = 8'hFF,
	output logic            rd_out = 1'b0,
	output logic            wr_out = 1'b0,
	output logic            strobe_out = 1'b0,
	output logic            csel_n_out = 1'b1,
	output logic            be_n_out = 1'b1
);
	// one access per call; starts on a falling edge so calls never collide
	task automatic xfer(input logic is_wr, input logic mux, input logic [7:0] ofs, input logic [7:0] wdat,
			output logic [7:0] rdat, output logic ok);
		@(negedge sys_clk_in);
		if (mux) begin
			addr_out = {base_in, ~ofs};
			data_out = ofs;
			strobe_out = 1'b1;
			@(negedge sys_clk_in);
			strobe_out = 1'b0;
			data_out = ~ofs;
			@(negedge sys_clk_in);
		end
		addr_out = {base_in, mux ? ~ofs : ofs};
		data_out = wdat;
		csel_n_out = refuse_cs_in;
		be_n_out = refuse_be_in;
		wr_out = is_wr;
		rd_out = !is_wr;
		@(negedge sys_clk_in);
		rdat = rdata_in;
		ok = rvalid_in;
		rd_out = 1'b0;
		wr_out = 1'b0;
		csel_n_out = 1'b1;
		be_n_out = 1'b1;
		// released bus shows inverted values, not the last ones
		addr_out = ~addr_out;
		data_out = ~wdat;
	endtask
endmodule

// ### bench/iorw_io_register_window_tb.sv
// self-checking bench for the i/o register window
`timescale 1ns/1ps
module iorw_io_register_window_tb
	import iorw_pkg::*;
	;
	logic           sys_clk_in = 1'b0;
	logic           rst_n_in = 1'b0;
	logic [7:0]     window_base_in = 8'h5C;
	logic [7:0]     hbase = 8'h5C;
	iorw_host_t     host_type_in = IORW_HOST_NON_MUX;
	iorw_pin_func_t pin_func_in = '0;
	iorw_ports_t    pins = 32'h96691E02;
	logic [7:0]     cell_ab_d_in = 8'h00, cell_bc_d_in = 8'h00, rv;
	logic [7:0]     primary_protect_in = 8'h3A, secondary_security_in = 8'hC5;
	logic           debug_tdo_in = 1'b0, refuse_cs = 1'b0, refuse_be = 1'b0;
	logic [15:0]    host_addr_in, fast_slew_out;
	logic [7:0]     host_data_in, host_rdata_out, cell_ab_out, cell_bc_out;
	logic [7:0]     power_control_0_out, power_control_2_out, page_select_out;
	logic [7:0]     memory_space_placement_out, debug_port_enable_out;
	logic           host_rd_in, host_wr_in, host_rvalid_out, debug_tdi_out, memory_enable_out;
	logic           auto_powerdown_out, strobe, csel_n, be_n, ok;
	iorw_ports_t    port_pin_in, port_pin_out, port_pin_oe_out;
	int             num_errors = 0, checked = 0, cycles = 0;

	assign port_pin_in = {pins.a, pins.b, be_n, pins.c[6:0], 5'h00, csel_n, pins.d[1], strobe};
	always #5 sys_clk_in = ~sys_clk_in;

	iorw_io_register_window i_dut (.sys_clk_in, .rst_n_in, .window_base_in, .host_type_in, .pin_func_in,
		.host_addr_in, .host_data_in, .host_rd_in, .host_wr_in, .port_pin_in, .cell_ab_d_in, .cell_bc_d_in,
		.primary_protect_in, .secondary_security_in, .debug_tdo_in, .host_rdata_out, .host_rvalid_out,
		.port_pin_out, .port_pin_oe_out, .fast_slew_out, .cell_ab_out, .cell_bc_out, .power_control_0_out,
		.power_control_2_out, .page_select_out, .memory_space_placement_out, .debug_port_enable_out,
		.debug_tdi_out, .memory_enable_out, .auto_powerdown_out);
	iorw_host_model i_host (.sys_clk_in, .base_in(hbase), .refuse_cs_in(refuse_cs), .refuse_be_in(refuse_be),
		.rdata_in(host_rdata_out), .rvalid_in(host_rvalid_out), .addr_out(host_addr_in), .data_out(host_data_in),
		.rd_out(host_rd_in), .wr_out(host_wr_in), .strobe_out(strobe), .csel_n_out(csel_n), .be_n_out(be_n));

	task automatic finish_test;
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		i_host.xfer(1'b1, 1'b0, o, d, rv, ok);
	endtask
	task automatic rd(input logic [7:0] o, input logic [7:0] exp);
		i_host.xfer(1'b0, 1'b0, o, 8'h00, rv, ok);
		chk1(ok, 1'b1);
		chk8(rv, exp);
	endtask

	always @(posedge sys_clk_in) begin
		cycles++;
		// whole run needs well under a thousand cycles
		if (cycles == 3000) begin
			num_errors++;
			$display("[FAIL] %0t run hung", $time);
			finish_test();
		end
	end

	initial begin
		logic [7:0] rw [21] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h12, 8'h13, 8'h14,
			8'h15, 8'h16, 8'h17, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hC7, 8'hE0, 8'hE2};
		logic [7:0] ea [3] = '{8'hC0, 8'hCC, 8'h3C};
		logic [7:0] eb [3] = '{8'hC0, 8'hFC, 8'h5C};
		logic [7:0] wd;
		idle(20);
		rst_n_in = 1'b1;
		idle(2);
		chk1(memory_enable_out, 1'b1);
		foreach (rw[i]) begin
			// port d keeps three pins only, so stay inside them
			wd = (rw[i] inside {8'h13, 8'h15, 8'h17}) ? 8'h05 : ~rw[i];
			wr(rw[i], wd);
			rd(rw[i], wd);
		end
		chk8(power_control_2_out, 8'h4B);
		chk8(memory_space_placement_out, 8'h1D);
		idle(250);
		chk1(auto_powerdown_out, 1'b0);
		idle(10);
		chk1(auto_powerdown_out, 1'b1);
		wr(OFS_PRI_PROT, 8'hFF);
		chk1(auto_powerdown_out, 1'b0);
		wr(OFS_SEC_PROT, 8'hFF);
		wr(8'h30, 8'hFF);
		rd(OFS_PRI_PROT, 8'h3A);
		rd(OFS_SEC_PROT, 8'hC5);
		rd(8'h30, 8'h00);
		rd(8'hFF, 8'h00);
		hbase = 8'h5D;
		i_host.xfer(1'b0, 1'b0, OFS_PRI_PROT, 8'h00, rv, ok);
		chk1(ok, 1'b0);
		hbase = 8'h5C;
		rd(OFS_A_PIN, 8'h96);
		rd(OFS_B_PIN, 8'h69);
		rd(OFS_C_PIN, 8'h9E);
		rd(OFS_D_PIN, 8'h06);
		wr(OFS_A_DRV, 8'h00);
		wr(OFS_A_MODE, 8'h00);
		wr(OFS_A_DIR, 8'hFF);
		wr(OFS_A_OUT, 8'h3C);
		idle(3);
		chk8(port_pin_out.a, 8'h3C);
		chk8(port_pin_oe_out.a, 8'hFF);
		wr(OFS_A_DRV, 8'hF5);
		idle(3);
		chk8(port_pin_out.a, 8'h0C);
		chk8(port_pin_oe_out.a, 8'hCF);
		chk8({4'h0, fast_slew_out[3:0]}, 8'h05);
		rd(OFS_A_OE, 8'hCF);
		wr(OFS_A_DRV, 8'h00);
		wr(OFS_B_DRV, 8'h00);
		wr(OFS_B_DIR, 8'hFF);
		wr(OFS_A_MODE, 8'hFF);
		wr(OFS_B_MODE, 8'hFF);
		pin_func_in.strobe_on_d0 = 1'b1;
		for (int t = 0; t < 3; t++) begin
			host_type_in = iorw_host_t'(t);
			i_host.xfer(1'b0, 1'b1, OFS_PRI_PROT, 8'h00, rv, ok);
			chk8(rv, 8'h3A);
			idle(3);
			chk8(port_pin_out.a, ea[t]);
			chk8(port_pin_out.b, eb[t]);
		end
		pin_func_in.strobe_on_d0 = 1'b0;
		host_type_in = IORW_HOST_NON_MUX;
		pin_func_in.logic_clk_on_d1 = 1'b1;
		pins.d[1] = 1'b0;
		wr(OFS_MASK_AB, 8'hF0);
		wr(OFS_MASK_BC, 8'h0F);
		wr(OFS_CELL_AB, 8'hFF);
		wr(OFS_CELL_BC, 8'hFF);
		rd(OFS_CELL_AB, 8'h0F);
		rd(OFS_CELL_BC, 8'hF0);
		cell_ab_d_in = 8'hA5;
		cell_bc_d_in = 8'h5A;
		pins.d[1] = 1'b1;
		idle(4);
		chk8(cell_ab_out, 8'hA5);
		chk8(cell_bc_out, 8'h5A);
		pin_func_in.chip_sel_on_d2 = 1'b1;
		idle(2);
		chk1(memory_enable_out, 1'b0);
		refuse_cs = 1'b1;
		i_host.xfer(1'b0, 1'b0, OFS_PAGE, 8'h00, rv, ok);
		chk1(ok, 1'b0);
		refuse_cs = 1'b0;
		rd(OFS_PAGE, 8'h1F);
		pin_func_in.byte_en_on_c7 = 1'b1;
		refuse_be = 1'b1;
		wr(OFS_PAGE, 8'h77);
		i_host.xfer(1'b0, 1'b0, OFS_PAGE, 8'h00, rv, ok);
		chk1(ok, 1'b0);
		refuse_be = 1'b0;
		rd(OFS_PAGE, 8'h1F);
		wr(OFS_C_DRV, 8'h00);
		pins.c[5] = 1'b1;
		debug_tdo_in = 1'b1;
		idle(3);
		chk1(debug_tdi_out, 1'b1);
		chk1(port_pin_out.c[6], 1'b1);
		chk1(port_pin_oe_out.c[6], 1'b1);
		chk8(debug_port_enable_out, 8'h38);
		chk8(page_select_out, 8'h1F);
		rd(OFS_A_ICELL, 8'h96);
		rd(OFS_D_OE, 8'h01);
		finish_test();
	end
endmodule
